/* sfr_page_pkg.sv */
// shared constants and carrier types for the core special register page
package sfr_page_pkg;

  // register offsets within the low page
  localparam logic [6:0] ADDR_INDIRECT_DATA = 7'h00;
  localparam logic [6:0] ADDR_TIMER0_VALUE  = 7'h01;
  localparam logic [6:0] ADDR_PC_LOW        = 7'h02;
  localparam logic [6:0] ADDR_ARITH_FLAGS   = 7'h03;
  localparam logic [6:0] ADDR_INDIRECT_PTR  = 7'h04;
  localparam logic [6:0] ADDR_PORT_A_DATA   = 7'h05;
  localparam logic [6:0] ADDR_PORT_B_DATA   = 7'h06;
  localparam logic [6:0] ADDR_POWER_CONTROL = 7'h08;
  localparam logic [6:0] ADDR_PC_HIGH_BUF   = 7'h0A;
  localparam logic [6:0] ADDR_SFR_LAST      = 7'h1F;
  localparam logic [6:0] ADDR_GPR_FIRST     = 7'h20;
  localparam logic [6:0] ADDR_GPR_BANK1_END = 7'h3F;

  // field positions in the flags register
  localparam int FLAG_CARRY       = 0;
  localparam int FLAG_NIBBLE      = 1;
  localparam int FLAG_ZERO        = 2;
  localparam int FLAG_SLEEP_N     = 3;
  localparam int FLAG_WDT_EXPIRY  = 4;
  localparam int FLAG_SPARE5      = 5;
  localparam int FLAG_BANK_LO     = 6;

  // field positions in the power control register
  localparam int PWR_WDT_EN       = 7;
  localparam int PWR_UVD_EN       = 5;
  localparam int PWR_PA5_PULL_OFF = 4;
  localparam int PWR_LVR_EN       = 3;

  // reset values
  localparam logic [7:0]  RESET_FLAGS      = 8'h18;
  localparam logic [7:0]  RESET_POWER_CTRL = 8'h98;
  localparam logic [7:0]  RESET_PTR        = 8'h00;
  localparam logic [10:0] RESET_PC         = 11'h000;
  localparam logic [2:0]  RESET_PC_HIGH    = 3'h0;
  localparam logic [7:0]  RESET_TIMER0     = 8'h00;

  // timer0 clock source selection
  typedef enum logic [1:0] {
    T0_SRC_INSTR,
    T0_SRC_EXT_PIN,
    T0_SRC_LOW_OSC
  } timer0_src_type;

  // control and data from the instruction core, one instruction per cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic        advance;     // instruction completes, pc steps by one
    logic        long_jump;   // load pc from instruction word
    logic        long_call;   // load pc and push return address
    logic [10:0] target;      // address field of the instruction word
    logic        flags_we;    // alu result updates the arithmetic flags
    logic        carry;
    logic        nibble_carry;
    logic        zero;
    logic        clear_wdt;   // watchdog clear instruction
    logic        sleep;       // sleep instruction
    logic        wdt_timeout;
  } core_req_type;

endpackage : sfr_page_pkg

/* core_special_register_page.sv */
// core special register page: indirect port, timer0, pc, flags, ports, power
// Summary of operation
// - indirect data port redirects every access to the register the pointer names
// - timer0 read returns live count; write overwrites the count
// - timer0 ticks from instruction clock, external pin or low oscillator
// - pc low is bits 7:0 of 11-bit pc, resets zero, steps per instruction
// - pc bits 10:8 take the pc high buffer on a pc low write, and also change by jump, call or step carry
// - long jump loads all eleven pc bits from the instruction word
// - long call loads pc and pushes pc plus one onto the stack
// - carry set on addition carry or subtraction without borrow
// - nibble carry set on carry out of bit three, or no borrow
// - zero flag set when the logical result is zero
// - sleep flag reads one after power-up or watchdog clear, zero after sleep
// - expiry flag set by power-up, clear or sleep; cleared on watchdog timeout
// - flag bits 7:6 select the data bank, reset to bank zero
// - pointer low seven bits pick one of 128 registers; bit 7 is storage
// - port read gives pin for inputs, pin or latch for outputs by option
// - port write stores into the output latches regardless of direction
// - port b bits 7 and 6 are plain storage bits
// - power control bit 7 enables the watchdog, resets to one
// - power control bit 5 enables the undervolt detector, resets to zero
// - bit 4 low enables port a5 pull-up, bit 3 enables low-volt reset
// - power control bits 6, 2, 1, 0 are storage resetting to zero
// - registers 0x0 to 0x1F exist in bank zero only; other banks map back
// - data memory at 0x20-0x7F bank zero and 0x20-0x3F bank one
module core_special_register_page
  import sfr_page_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire sfr_page_pkg::core_req_type core_req,
  output logic [7:0]                      rdata,
  output logic [10:0]                     program_counter,
  output logic [10:0]                     stack_top,
  output logic [1:0]                      bank_select,
  input  wire logic [1:0]                 timer0_mode_select,
  input  wire logic                       cfg_low_osc_select,
  input  wire logic                       output_readback_option,
  input  wire logic                       ext_timer_clock_pin,
  input  wire logic                       low_osc_tick,
  input  wire logic [7:0]                 port_a_dir_in,
  input  wire logic [5:0]                 port_b_dir_in,
  input  wire logic [7:0]                 port_a_pin_in,
  input  wire logic [5:0]                 port_b_pin_in,
  output logic [7:0]                      port_a_out,
  output logic [5:0]                      port_b_out,
  output logic                            watchdog_enable,
  output logic                            undervolt_detect_enable,
  output logic                            port_a5_pullup_off,
  output logic                            low_volt_reset_enable,
  output logic                            timer0_overflow
);

  // synchronised pin inputs
  logic [7:0] pa_meta;
  logic [7:0] pa_sync;
  logic [5:0] pb_meta;
  logic [5:0] pb_sync;
  logic       ext_meta;
  logic       ext_sync;
  logic       ext_prev;

  // register state
  logic [7:0]  flags;
  logic [7:0]  indirect_pointer;
  logic [7:0]  timer0_count;
  logic [7:0]  power_control;
  logic [2:0]  pc_high_buffer;
  logic [7:0]  port_a_latch;
  logic [7:0]  port_b_latch;
  logic [10:0] pc;
  logic [7:0]  gpr_bank0 [96];
  logic [7:0]  gpr_bank1 [32];
  logic [10:0] stack_mem [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] stack_ptr;

  // decoded access
  logic [6:0]  eff_addr;
  logic [1:0]  eff_bank;
  logic        acc_sfr;
  logic        acc_bank1;
  logic        wr_en;
  logic        timer0_tick;
  logic [7:0]  next_rdata;
  logic [7:0]  port_a_view;
  logic [7:0]  port_b_view;
  logic [6:0]  gpr0_index;
  logic [4:0]  gpr1_index;
  logic        wr_timer0;
  logic        wr_pc_low;
  logic        wr_pc_high;
  logic        wr_flags;
  logic        wr_pointer;
  logic        wr_port_a;
  logic        wr_port_b;
  logic        wr_power;
  logic        stack_used;

  // two-stage synchronisers for port pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pa_meta <= 8'h00;
      pa_sync <= 8'h00;
      pb_meta <= 6'h00;
      pb_sync <= 6'h00;
    end else begin
      pa_meta <= port_a_pin_in;
      pa_sync <= pa_meta;
      pb_meta <= port_b_pin_in;
      pb_sync <= pb_meta;
    end
  end

  // timer clock pin synchroniser and edge history, idle low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_timer_clock_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // address resolution: indirect via pointer, direct via bank select
  always_comb begin
    if (core_req.addr == ADDR_INDIRECT_DATA) begin
      eff_addr = indirect_pointer[6:0];
    end else begin
      eff_addr = core_req.addr;
    end
    eff_bank   = flags[7:6];
    acc_sfr    = (eff_addr <= ADDR_SFR_LAST);
    // banks 2 and 3 fold onto 0 and 1 below 0x40; above, all fold to bank 0
    acc_bank1  = eff_bank[0] && (eff_addr <= ADDR_GPR_BANK1_END) && !acc_sfr;
    gpr0_index = eff_addr - ADDR_GPR_FIRST;
    gpr1_index = gpr0_index[4:0];
    wr_en      = core_req.wr;
  end

  // per-register write strobes within the special page
  always_comb begin
    wr_timer0  = wr_en && acc_sfr && (eff_addr == ADDR_TIMER0_VALUE);
    wr_pc_low  = wr_en && acc_sfr && (eff_addr == ADDR_PC_LOW);
    wr_pc_high = wr_en && acc_sfr && (eff_addr == ADDR_PC_HIGH_BUF);
    wr_flags   = wr_en && acc_sfr && (eff_addr == ADDR_ARITH_FLAGS);
    wr_pointer = wr_en && acc_sfr && (eff_addr == ADDR_INDIRECT_PTR);
    wr_port_a  = wr_en && acc_sfr && (eff_addr == ADDR_PORT_A_DATA);
    wr_port_b  = wr_en && acc_sfr && (eff_addr == ADDR_PORT_B_DATA);
    wr_power   = wr_en && acc_sfr && (eff_addr == ADDR_POWER_CONTROL);
  end

  // timer0 source select
  always_comb begin
    if (timer0_mode_select == T0_SRC_EXT_PIN) begin
      timer0_tick = ext_sync && !ext_prev;
    end else if (timer0_mode_select == T0_SRC_LOW_OSC && cfg_low_osc_select) begin
      timer0_tick = low_osc_tick;
    end else begin
      timer0_tick = core_req.advance;
    end
  end

  // timer0 count, writes override counting
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer0_count <= RESET_TIMER0;
    end else if (wr_timer0) begin
      timer0_count <= core_req.wdata;
    end else if (timer0_tick) begin
      timer0_count <= timer0_count + 8'h01;
    end
  end

  // one-cycle overflow pulse on the wrap to zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer0_overflow <= 1'b0;
    end else if (wr_timer0) begin
      timer0_overflow <= 1'b0;
    end else begin
      timer0_overflow <= timer0_tick && (timer0_count == 8'hFF);
    end
  end

  // program counter: call beats jump beats pc low write beats step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pc <= RESET_PC;
    end else if (core_req.long_call) begin
      pc <= core_req.target;
    end else if (core_req.long_jump) begin
      pc <= core_req.target;
    end else if (wr_pc_low) begin
      pc <= {pc_high_buffer, core_req.wdata};
    end else if (core_req.advance) begin
      pc <= pc + 11'h001;
    end
  end

  // hardware stack: a call pushes the return address
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stack_ptr  <= '0;
      stack_used <= 1'b0;
    end else if (core_req.long_call) begin
      stack_mem[stack_ptr] <= pc + 11'h001;
      stack_ptr            <= stack_ptr + 1'b1;
      stack_used           <= 1'b1;
    end
  end

  // pc high buffer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pc_high_buffer <= RESET_PC_HIGH;
    end else if (wr_pc_high) begin
      pc_high_buffer <= core_req.wdata[2:0];
    end
  end

  // arithmetic flags, reset cause and bank select
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= RESET_FLAGS;
    end else begin
      if (wr_flags) begin
        flags <= core_req.wdata;
      end
      if (core_req.flags_we) begin
        flags[FLAG_CARRY]  <= core_req.carry;
        flags[FLAG_NIBBLE] <= core_req.nibble_carry;
        flags[FLAG_ZERO]   <= core_req.zero;
      end
      if (core_req.clear_wdt) begin
        flags[FLAG_SLEEP_N]    <= 1'b1;
        flags[FLAG_WDT_EXPIRY] <= 1'b1;
      end
      if (core_req.sleep) begin
        flags[FLAG_SLEEP_N]    <= 1'b0;
        flags[FLAG_WDT_EXPIRY] <= 1'b1;
      end
      if (core_req.wdt_timeout) begin
        flags[FLAG_WDT_EXPIRY] <= 1'b0;
      end
    end
  end

  // indirect pointer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      indirect_pointer <= RESET_PTR;
    end else if (wr_pointer) begin
      indirect_pointer <= core_req.wdata;
    end
  end

  // port a output latch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_a_latch <= 8'h00;
    end else if (wr_port_a) begin
      port_a_latch <= core_req.wdata;
    end
  end

  // port b output latch, bits 7:6 are plain storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_b_latch <= 8'h00;
    end else if (wr_port_b) begin
      port_b_latch <= core_req.wdata;
    end
  end

  // power control
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      power_control <= RESET_POWER_CTRL;
    end else if (wr_power) begin
      power_control <= core_req.wdata;
    end
  end

  // general purpose data memory
  always_ff @(posedge sys_clk) begin
    if (wr_en && !acc_sfr) begin
      if (acc_bank1) begin
        gpr_bank1[gpr1_index] <= core_req.wdata;
      end else begin
        gpr_bank0[gpr0_index] <= core_req.wdata;
      end
    end
  end

  // port readback: direction 1 means input
  always_comb begin
    port_a_view = (port_a_dir_in & pa_sync)
                | (~port_a_dir_in & (output_readback_option ? port_a_latch : pa_sync));
    port_b_view = {port_b_latch[7:6],
                   (port_b_dir_in & pb_sync)
                   | (~port_b_dir_in & (output_readback_option ? port_b_latch[5:0]
                                                                : pb_sync))};
  end

  // read multiplexer
  always_comb begin
    next_rdata = 8'h00;
    if (!acc_sfr) begin
      next_rdata = acc_bank1 ? gpr_bank1[gpr1_index] : gpr_bank0[gpr0_index];
    end else if (eff_addr == ADDR_TIMER0_VALUE) begin
      next_rdata = timer0_count;
    end else if (eff_addr == ADDR_PC_LOW) begin
      next_rdata = pc[7:0];
    end else if (eff_addr == ADDR_ARITH_FLAGS) begin
      next_rdata = flags;
    end else if (eff_addr == ADDR_INDIRECT_PTR) begin
      next_rdata = indirect_pointer;
    end else if (eff_addr == ADDR_PORT_A_DATA) begin
      next_rdata = port_a_view;
    end else if (eff_addr == ADDR_PORT_B_DATA) begin
      next_rdata = port_b_view;
    end else if (eff_addr == ADDR_POWER_CONTROL) begin
      next_rdata = power_control;
    end else if (eff_addr == ADDR_PC_HIGH_BUF) begin
      next_rdata = {5'h00, pc_high_buffer};
    end
  end

  // read data, held until the next read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (core_req.rd) begin
      rdata <= next_rdata;
    end
  end

  // pc, stack top and bank copies; empty stack shows zero, not stale memory
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      program_counter <= RESET_PC;
      stack_top       <= 11'h000;
      bank_select     <= 2'h0;
    end else begin
      program_counter <= pc;
      stack_top       <= stack_used ? stack_mem[stack_ptr - 1'b1] : 11'h000;
      bank_select     <= flags[7:6];
    end
  end

  // port latch copies to the pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_a_out <= 8'h00;
      port_b_out <= 6'h00;
    end else begin
      port_a_out <= port_a_latch;
      port_b_out <= port_b_latch[5:0];
    end
  end

  // power control enables to the analog blocks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      watchdog_enable         <= 1'b1;
      undervolt_detect_enable <= 1'b0;
      port_a5_pullup_off      <= 1'b1;
      low_volt_reset_enable   <= 1'b1;
    end else begin
      watchdog_enable         <= power_control[PWR_WDT_EN];
      undervolt_detect_enable <= power_control[PWR_UVD_EN];
      port_a5_pullup_off      <= power_control[PWR_PA5_PULL_OFF];
      low_volt_reset_enable   <= power_control[PWR_LVR_EN];
    end
  end

endmodule : core_special_register_page

/* sfr_page_props.sv */
// concurrent checks on the special register page ports
module sfr_page_props
  import sfr_page_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire sfr_page_pkg::core_req_type core_req,
  input  wire logic [7:0]                 rdata,
  input  wire logic [10:0]                program_counter,
  input  wire logic [10:0]                stack_top,
  input  wire logic [1:0]                 bank_select,
  input  wire logic [7:0]                 port_a_out,
  input  wire logic                       watchdog_enable,
  input  wire logic                       undervolt_detect_enable,
  input  wire logic                       port_a5_pullup_off,
  input  wire logic                       low_volt_reset_enable,
  input  wire logic                       timer0_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0]  wd1, wd2;
  logic [10:0] tg1, tg2;
  wire         wr_pcl = core_req.wr && core_req.addr == ADDR_PC_LOW;
  wire         wr_flg = core_req.wr && core_req.addr == ADDR_ARITH_FLAGS;
  wire         wr_pwr = core_req.wr && core_req.addr == ADDR_POWER_CONTROL;
  wire         wr_pa  = core_req.wr && core_req.addr == ADDR_PORT_A_DATA;
  wire         pc_ld  = core_req.long_jump || core_req.long_call;
  // write data and target as they were two edges back
  always_ff @(posedge sys_clk) begin
    wd1 <= core_req.wdata;
    wd2 <= wd1;
    tg1 <= core_req.target;
    tg2 <= tg1;
  end
  a_step_by_one: assert property (core_req.advance && !core_req.wr && !pc_ld
    |-> ##2 program_counter == $past(program_counter) + 11'h001) else $error("pc step wrong");
  a_pcl_read_live: assert property (core_req.rd && core_req.addr == ADDR_PC_LOW
    |=> rdata == program_counter[7:0]) else $error("pc low read wrong");
  a_pcl_load_low: assert property (wr_pcl && !pc_ld
    |-> ##2 program_counter[7:0] == wd2) else $error("pc low load wrong");
  a_jump_loads_pc: assert property (core_req.long_jump && !core_req.long_call
    |-> ##2 program_counter == tg2) else $error("jump target wrong");
  a_call_push_ret: assert property (core_req.long_call |-> ##2 program_counter == tg2
    && stack_top == $past(program_counter) + 11'h001) else $error("call push wrong");
  a_bank_follows: assert property (wr_flg |-> ##2 bank_select == wd2[7:6])
    else $error("bank select wrong");
  a_port_latch: assert property (wr_pa |-> ##2 port_a_out == wd2)
    else $error("port latch wrong");
  a_power_bits: assert property (wr_pwr |-> ##2 {watchdog_enable, undervolt_detect_enable,
    port_a5_pullup_off, low_volt_reset_enable} == {wd2[7], wd2[5], wd2[4], wd2[3]})
    else $error("power outputs wrong");
  a_unmapped_zero: assert property (core_req.rd && core_req.addr == 7'h07 |=> rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_rdata_holds: assert property (!core_req.rd |=> $stable(rdata))
    else $error("read data moved");
  a_ovf_one_cycle: assert property (timer0_overflow |=> !timer0_overflow)
    else $error("overflow pulse too long");
endmodule : sfr_page_props

bind core_special_register_page sfr_page_props #(.STACK_DEPTH(STACK_DEPTH)) props_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .core_req(core_req), .rdata(rdata),
  .program_counter(program_counter), .stack_top(stack_top), .bank_select(bank_select),
  .port_a_out(port_a_out), .watchdog_enable(watchdog_enable),
  .undervolt_detect_enable(undervolt_detect_enable), .port_a5_pullup_off(port_a5_pullup_off),
  .low_volt_reset_enable(low_volt_reset_enable), .timer0_overflow(timer0_overflow));

/* cpu_core_model.sv */
// instruction core model: one request per instruction cycle
module cpu_core_model
  import sfr_page_pkg::*;
(
  input  wire logic                  sys_clk,
  output sfr_page_pkg::core_req_type core_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial core_req = '0;
  // request launched after an edge, held until the next request
  task automatic issue(input core_req_type r);
    @(posedge sys_clk);
    core_req <= r;
  endtask : issue
endmodule : cpu_core_model

/* tb_top.sv */
// self-checking bench for the core special register page
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sfr_page_pkg::*;
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  core_req_type core_req, r;
  logic [7:0]   rdata, pa_dir, pa_pin, pa_out, q;
  logic [5:0]   pb_dir, pb_pin, pb_out;
  logic [10:0]  pc, stk;
  logic [1:0]   bank, t0_mode;
  logic         opt, ext_pin, osc_tick, cfg_osc, wdt_en, uvd_en, pa5_off, lvr_en;
  logic [15:0]  lf = 16'h4B29;
  logic [15:0]  nz = 16'h4B29;
  int           error_cnt, checks, cyc, osc_cnt, t0;
  cpu_core_model cpu_u (.sys_clk(sys_clk), .core_req(core_req));
  core_special_register_page #(.STACK_DEPTH(8)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .core_req(core_req), .rdata(rdata), .program_counter(pc), .stack_top(stk),
    .bank_select(bank), .timer0_mode_select(t0_mode), .cfg_low_osc_select(cfg_osc),
    .output_readback_option(opt), .ext_timer_clock_pin(ext_pin), .low_osc_tick(osc_tick),
    .port_a_dir_in(pa_dir), .port_b_dir_in(pb_dir), .port_a_pin_in(pa_pin),
    .port_b_pin_in(pb_pin), .port_a_out(pa_out), .port_b_out(pb_out), .watchdog_enable(wdt_en),
    .undervolt_detect_enable(uvd_en), .port_a5_pullup_off(pa5_off),
    .low_volt_reset_enable(lvr_en), .timer0_overflow());
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // expected port read: inputs give pin, outputs give latch or pin by option
  function automatic logic [7:0] pmux(input logic [7:0] d, p, l, input logic o);
    return (d & p) | (~d & (o ? l : p));
  endfunction : pmux
  function automatic core_req_type mk(input logic rd, wr, input logic [6:0] a, input logic [7:0] d);
    mk = '0;
    mk.rd = rd;
    mk.wr = wr;
    mk.addr = a;
    mk.wdata = d;
  endfunction : mk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cpu_u.issue(mk(1'b0, 1'b1, a, d));
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    cpu_u.issue(mk(1'b1, 1'b0, a, 8'h00));
    cpu_u.issue('0);
    #1 v = rdata;
  endtask : rd
  // run one instruction, then let the registered pc copy settle
  task automatic pc_op(input core_req_type c, input logic [10:0] e);
    cpu_u.issue(c);
    cpu_u.issue('0);
    @(posedge sys_clk);
    #1 `CHK(pc, e)
  endtask : pc_op
  task automatic final_report();
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  always #5 sys_clk = ~sys_clk;
  // random timer source chatter and hang guard
  always @(posedge sys_clk) begin
    nz = lfsr(nz);
    ext_pin  <= nz[3];
    osc_tick <= nz[7];
    cfg_osc  <= nz[9];
    // low oscillator ticks that the page sees while in that mode
    if (t0_mode == 2'd2 && cfg_osc && osc_tick) osc_cnt <= osc_cnt + 1;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    {pa_dir, pa_pin, pb_dir, pb_pin, t0_mode, opt, ext_pin, osc_tick, cfg_osc} = '0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_ARITH_FLAGS, q);
    `CHK(q[7:3], 5'b00011)
    rd(ADDR_POWER_CONTROL, q);
    `CHK(q, 8'h98)
    rd(ADDR_PC_LOW, q);
    `CHK(q, 8'h00)
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wr(ADDR_POWER_CONTROL, lf[7:0]);
      rd(ADDR_POWER_CONTROL, q);
      `CHK(q, lf[7:0])
      `CHK({wdt_en, uvd_en, pa5_off, lvr_en}, {lf[7], lf[5], lf[4], lf[3]})
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      @(posedge sys_clk);
      {pa_pin, pb_pin} <= {lf[15:8], lf[13:8]};
      {pa_dir, pb_dir} <= {lf[7:0] ^ 8'h5A, lf[5:0]};
      opt <= lf[2];
      wr(ADDR_PORT_A_DATA, lf[7:0] ^ 8'hC3);
      rd(ADDR_PORT_A_DATA, q);
      `CHK(q, pmux(lf[7:0] ^ 8'h5A, lf[15:8], lf[7:0] ^ 8'hC3, lf[2]))
      `CHK(pa_out, lf[7:0] ^ 8'hC3)
      wr(ADDR_PORT_B_DATA, lf[15:8]);
      rd(ADDR_PORT_B_DATA, q);
      `CHK(q, {lf[15:14], 6'(pmux({2'b00, lf[5:0]}, {2'b00, lf[13:8]}, lf[15:8], lf[2]))})
      `CHK(pb_out, lf[13:8])
    end
    @(posedge sys_clk);
    pa_dir <= 8'h00;
    opt <= 1'b1;
    wr(ADDR_INDIRECT_PTR, 8'h85);
    wr(ADDR_INDIRECT_DATA, 8'h3C);
    rd(ADDR_PORT_A_DATA, q);
    `CHK(q, 8'h3C)
    rd(ADDR_INDIRECT_PTR, q);
    `CHK(q, 8'h85)
    wr(ADDR_INDIRECT_PTR, 8'h00);
    rd(ADDR_INDIRECT_DATA, q);
    `CHK(q, 8'h00)
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      r = '0;
      {r.flags_we, r.carry, r.nibble_carry, r.zero} = {1'b1, lf[2:0]};
      cpu_u.issue(r);
      rd(ADDR_ARITH_FLAGS, q);
      `CHK(q[2:0], {lf[0], lf[1], lf[2]})
    end
    for (int k = 0; k < 3; k++) begin
      r = '0;
      {r.wdt_timeout, r.sleep, r.clear_wdt} = 3'b100 >> k;
      cpu_u.issue(r);
      rd(ADDR_ARITH_FLAGS, q);
      `CHK(q[4:3], k == 0 ? 2'b01 : k == 1 ? 2'b10 : 2'b11)
    end
    wr(ADDR_POWER_CONTROL, 8'h5A);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_ARITH_FLAGS, {b[1:0], 6'h18});
      if (b < 2) wr(ADDR_GPR_FIRST, 8'hA5 ^ {8{b[0]}});
      rd(ADDR_GPR_FIRST, q);
      `CHK(q, 8'hA5 ^ {8{b[0]}})
      rd(ADDR_POWER_CONTROL, q);
      `CHK(q, 8'h5A)
      `CHK(bank, b[1:0])
    end
    wr(ADDR_ARITH_FLAGS, 8'h18);
    wr(7'h07, 8'hFF);
    rd(7'h07, q);
    `CHK(q, 8'h00)
    @(posedge sys_clk);
    t0_mode <= 2'd2;
    wr(ADDR_TIMER0_VALUE, 8'h00);
    cpu_u.issue('0);
    @(posedge sys_clk);
    t0 = osc_cnt;
    repeat (40) @(posedge sys_clk);
    t0_mode <= 2'd0;
    repeat (2) @(posedge sys_clk);
    rd(ADDR_TIMER0_VALUE, q);
    `CHK(q, 8'(osc_cnt - t0))
    wr(ADDR_TIMER0_VALUE, 8'hFD);
    r = '0;
    r.advance = 1'b1;
    repeat (3) cpu_u.issue(r);
    rd(ADDR_TIMER0_VALUE, q);
    `CHK(q, 8'h00)
    wr(ADDR_PC_HIGH_BUF, 8'h05);
    pc_op(mk(1'b0, 1'b1, ADDR_PC_LOW, 8'h34), 11'h534);
    r = '0;
    {r.long_jump, r.target} = {1'b1, 11'h7FF};
    pc_op(r, 11'h7FF);
    r = '0;
    {r.long_call, r.target} = {1'b1, 11'h0AB};
    pc_op(r, 11'h0AB);
    `CHK(stk, 11'h800)
    r = '0;
    r.advance = 1'b1;
    pc_op(r, 11'h0AC);
    final_report();
  end
endmodule : tb_top
